/* evt_status_bank.sv */
// Sticky interrupt status bits, one per implemented event.
// Assumes event and clear inputs are synchronous one-cycle requests.
`timescale 1ns/1ps
`default_nettype none
module evt_status_bank (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Requests
  input  wire logic [15:0] i_set,    // Event pulses
  input  wire logic [15:0] i_clr,    // Clear requests
  // State
  output var  logic [15:0] o_status  // Sticky status
);
  import phy_mgmt_pkg::*;
  wire logic [15:0] status_nxt;  // Next value of every flag
  // ******************************
  // Per-bit next values
  // ******************************
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_bit
      if (EV_IMPL[g]) begin : g_impl
        // Set wins over a clear in the same cycle
        assign status_nxt[g] = i_set[g]
                             | (o_status[g] & ~i_clr[g]);
      end else begin : g_rsvd
        // Unimplemented events read as zero
        assign status_nxt[g] = 1'b0;
      end
    end
  endgenerate
  // ******************************
  // Flag register
  // ******************************
  // One process owns the whole word, so no bit has two drivers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status <= 16'h0000;
    end else begin
      o_status <= status_nxt;
    end
  end
endmodule // evt_status_bank
`default_nettype wire

/* link_partner_model.sv */
// Behavioural far side of the page exchange: drives the negotiation inputs.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  // Clock
  input  wire logic i_clk_sys,
  // Negotiation side
  output var  logic o_lcw_ok,       // Consistent word seen
  output var  logic o_base_sent,    // Base page pulse
  output var  logic o_base_toggle,  // Toggle of base page
  output var  logic o_np_sent       // Next page pulse
);
  // ************************************
  // Idle levels at time zero
  // ************************************
  initial begin
    o_lcw_ok      = 1'b0;
    o_base_sent   = 1'b0;
    o_base_toggle = 1'b1;
    o_np_sent     = 1'b0;
  end
  // Level of the consistency flag
  task automatic set_ok(input logic v);
    @(posedge i_clk_sys);
    o_lcw_ok <= v;
  endtask
  // One-cycle base page; toggle qualifies only that cycle
  task automatic send_base(input logic t);
    @(posedge i_clk_sys);
    o_base_sent   <= 1'b1;
    o_base_toggle <= t;
    @(posedge i_clk_sys);
    o_base_sent   <= 1'b0;
    o_base_toggle <= ~t;  // Not held, so a late sample shows up
  endtask
  // One-cycle next page pulse
  task automatic send_np();
    @(posedge i_clk_sys);
    o_np_sent <= 1'b1;
    @(posedge i_clk_sys);
    o_np_sent <= 1'b0;
  endtask
endmodule // link_partner_model
`default_nettype wire

/* next_page_tx_and_irq_mask.sv */
// Next-page transmit and interrupt mask registers behind an APB slave.
// Assumes synchronous inputs, one clock, event inputs as single pulses.
`timescale 1ns/1ps
`default_nettype none
module next_page_tx_and_irq_mask (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  // Negotiation engine
  input  wire logic        i_lcw_ok,
  input  wire logic        i_base_sent,
  input  wire logic        i_base_toggle,
  input  wire logic        i_np_sent,
  output logic [15:0]      o_np_word,
  // Event sources, one-cycle pulses
  input  wire logic        i_carrier_monitor_link_unstable,
  input  wire logic        i_link_change,
  input  wire logic        i_descr_lock_change,
  input  wire logic        i_premature_end,
  input  wire logic        i_reset_done,
  input  wire logic        i_an_done,
  input  wire logic        i_page_rcvd,
  // Interrupt request
  output logic             o_irq_n
);
  import phy_mgmt_pkg::*;

  // ******************************
  // Declarations
  // ******************************
  logic [15:0] np_r;        // Writable page bits
  logic [15:0] mask_r;      // Interrupt enables
  logic        compat_r;    // Legacy compatibility mode
  logic [15:0] status;      // Sticky event flags
  logic [15:0] ev_set;      // Event pulses by bit
  logic [15:0] ev_clr;      // Clears by bit
  logic        ack_s;       // Acknowledge from sync control
  logic        toggle_s;    // Toggle from sync control
  logic [15:0] np_view;     // Page word as read
  logic        setup;       // Setup phase seen
  logic        done;        // Access completing this edge
  logic        wr_en;       // Write takes effect
  logic        rd_en;       // Read completes
  logic        hit_np;      // Decode results
  logic        hit_mask;
  logic        hit_stat;
  logic        hit_cfg;
  logic [15:0] rd_val;      // Read mux
  logic        rd_err;      // Unmapped address

  // ******************************
  // APB phase tracking
  // ******************************
  assign setup = i_psel & ~i_penable;
  assign done  = i_psel & i_penable & o_pready;
  assign wr_en = done & i_pwrite;
  assign rd_en = done & ~i_pwrite;

  // ******************************
  // Address decode
  // ******************************
  always_comb begin
    hit_np   = 1'b0;
    hit_mask = 1'b0;
    hit_stat = 1'b0;
    hit_cfg  = 1'b0;
    if (i_paddr == ADDR_NP) begin
      hit_np = 1'b1;
    end else if (i_paddr == ADDR_MASK) begin
      hit_mask = 1'b1;
    end else if (i_paddr == ADDR_STAT) begin
      hit_stat = 1'b1;
    end else if (i_paddr == ADDR_CFG) begin
      hit_cfg = 1'b1;
    end
  end

  // ******************************
  // Read mux
  // ******************************
  // Acknowledge and toggle come from the engine, never from software
  assign np_view = {np_r[15], ack_s, np_r[13:12], toggle_s, np_r[10:0]};

  always_comb begin
    rd_val = 16'h0000;
    rd_err = 1'b0;
    if (hit_np) begin
      rd_val = np_view;
    end else if (hit_mask) begin
      rd_val = mask_r;
    end else if (hit_stat) begin
      rd_val = status;
    end else if (hit_cfg) begin
      rd_val[CFG_COMPAT] = compat_r;
    end else begin
      rd_err = 1'b1;  // Unmapped: error answer
    end
  end

  // ******************************
  // Answer: one wait-free access
  // ******************************
  // Ready rises in the first access cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup;
    end
  end

  // Read data and error latched in the setup cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
      o_pslverr <= rd_err;
    end else if (done) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

  // ******************************
  // Configuration register
  // ******************************
  // Compatibility bit itself is always writable
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      compat_r <= 1'b0;
    end else if (wr_en && hit_cfg) begin
      compat_r <= i_pwdata[CFG_COMPAT];
    end
  end

  // ******************************
  // Next-page transmit register
  // ******************************
  // Reset value: message page, null message code
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      np_r <= NP_RST;
    end else if (wr_en && hit_np && !compat_r) begin
      // Read-only bits stay zero here, so writes cannot reach them
      np_r <= i_pwdata[15:0] & NP_WR_MASK;
    end
  end

  // Acknowledge and toggle held by the engine side
  np_sync_ctl u_np_sync (
    .i_clk_sys     (i_clk_sys),
    .i_nrst        (i_nrst),
    .i_lcw_ok      (i_lcw_ok),
    .i_base_sent   (i_base_sent),
    .i_base_toggle (i_base_toggle),
    .i_np_sent     (i_np_sent),
    .o_ack         (ack_s),
    .o_toggle      (toggle_s)
  );

  // Word offered to the link partner, registered
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_np_word <= NP_RST;
    end else begin
      o_np_word <= np_view;
    end
  end

  // ******************************
  // Interrupt enable mask
  // ******************************
  // Reset enables link change and reset complete only
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_r <= MASK_RST;
    end else if (wr_en && hit_mask && !compat_r) begin
      mask_r <= i_pwdata[15:0] & EV_IMPL;
    end
  end

  // ******************************
  // Event routing
  // ******************************
  always_comb begin
    ev_set = 16'h0000;
    ev_set[EV_UNSTABLE] = i_carrier_monitor_link_unstable;
    ev_set[EV_LINK]     = i_link_change;
    ev_set[EV_DESCR]    = i_descr_lock_change;
    ev_set[EV_PREMEND]  = i_premature_end;
    ev_set[EV_RSTDONE]  = i_reset_done;
    ev_set[EV_ANDONE]   = i_an_done;
    ev_set[EV_PAGE]     = i_page_rcvd;
  end

  // Read clears exactly the bits reported; write-one also clears.
  // Events after the setup capture survive the read.
  assign ev_clr = (rd_en && hit_stat) ? o_prdata[15:0] :
                  (wr_en && hit_stat) ? i_pwdata[15:0] : 16'h0000;

  // Status records events whatever the mask says
  evt_status_bank u_status (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_set     (ev_set),
    .i_clr     (ev_clr),
    .o_status  (status)
  );

  // ******************************
  // Interrupt request pin
  // ******************************
  // Active low while any enabled flag is pending
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= ~|(status & mask_r);
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  property p_np_more_wr;
    wr_en && hit_np && !compat_r |=> np_r[NP_MORE] == $past(i_pwdata[15]);
  endproperty
  a_np_more_wr: assert property (p_np_more_wr)
    else $error("more-pages bit did not take write");

  property p_ack_follow;
    i_lcw_ok ##1 i_lcw_ok |=> o_np_word[NP_ACK];
  endproperty
  a_ack_follow: assert property (p_ack_follow)
    else $error("acknowledge not offered after consistent data");

  property p_np_locked;
    wr_en && hit_np && compat_r |=> $stable(np_r);
  endproperty
  a_np_locked: assert property (p_np_locked)
    else $error("page written in compatibility mode");

  property p_mask_locked;
    wr_en && hit_mask && compat_r |=> $stable(mask_r);
  endproperty
  a_mask_locked: assert property (p_mask_locked)
    else $error("mask written in compatibility mode");

  property p_irq_assert;
    (status & mask_r) != 16'h0000 |=> !o_irq_n;
  endproperty
  a_irq_assert: assert property (p_irq_assert)
    else $error("enabled event did not assert request");

  property p_irq_release;
    (status & mask_r) == 16'h0000 |=> o_irq_n;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("request held without pending event");

  property p_masked_rec;
    i_carrier_monitor_link_unstable && !mask_r[EV_UNSTABLE]
      |=> status[EV_UNSTABLE] ##1 (o_irq_n || $past(status & mask_r) != 0);
  endproperty
  a_masked_rec: assert property (p_masked_rec)
    else $error("masked event not recorded or raised request");

  property p_rd_clear;
    rd_en && hit_stat && o_prdata[EV_LINK] && !i_link_change
      |=> !status[EV_LINK];
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("status read did not clear reported bit");

  property p_toggle_flip;
    i_np_sent && !i_base_sent |=> toggle_s != $past(toggle_s);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip)
    else $error("toggle did not invert on next page");

  // Selector and comply bits follow software when not locked
  property p_sel_wr;
    wr_en && hit_np && !compat_r
      |=> {np_r[NP_MSG], np_r[NP_COMPLY]} == $past(i_pwdata[NP_MSG:NP_COMPLY]);
  endproperty
  a_sel_wr: assert property (p_sel_wr)
    else $error("selector or comply bit did not take write");

  // Code field follows software when not locked
  property p_code_wr;
    wr_en && hit_np && !compat_r |=> np_r[10:0] == $past(i_pwdata[10:0]);
  endproperty
  a_code_wr: assert property (p_code_wr)
    else $error("code field did not take write");

  // A page write alone must never move the toggle
  property p_toggle_ro;
    wr_en && hit_np && !i_base_sent && !i_np_sent |=> $stable(toggle_s);
  endproperty
  a_toggle_ro: assert property (p_toggle_ro)
    else $error("software write moved the toggle");

  // Every event lands in status, masked or not
  property p_stat_rec;
    ev_set != 16'h0000 |=> (status & $past(ev_set)) == $past(ev_set);
  endproperty
  a_stat_rec: assert property (p_stat_rec)
    else $error("event not recorded in status");

  c_irq: cover property (!o_irq_n ##[1:20] o_irq_n);
  c_rd_clr: cover property (rd_en && hit_stat && o_prdata != 0);
  c_compat_wr: cover property (wr_en && hit_np && compat_r);
  c_np_seq: cover property (i_base_sent ##[1:50] i_np_sent);
  c_masked_ev: cover property (i_link_change && !mask_r[EV_LINK]);
endmodule // next_page_tx_and_irq_mask
`default_nettype wire

/* next_page_tx_and_irq_mask_tb_top.sv */
// Self-checking bench for the page and mask registers over APB.
// Assumes the design answers each APB access with one-cycle pready.
`timescale 1ns/1ps
`default_nettype none
module next_page_tx_and_irq_mask_tb_top;
  import phy_mgmt_pkg::*;
  // ************************************
  // Signals
  // ************************************
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] np_word;
  logic        lcw_ok, base_sent, base_tog, np_sent;
  logic [6:0]  ev;              // Event pulses, order of evb
  int          n_fail, checks_done;
  int          evb [7] = '{15, 14, 13, 12, 7, 5, 1};
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  next_page_tx_and_irq_mask uut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_lcw_ok(lcw_ok), .i_base_sent(base_sent), .i_base_toggle(base_tog),
    .i_np_sent(np_sent), .o_np_word(np_word),
    .i_carrier_monitor_link_unstable(ev[0]), .i_link_change(ev[1]),
    .i_descr_lock_change(ev[2]), .i_premature_end(ev[3]),
    .i_reset_done(ev[4]), .i_an_done(ev[5]), .i_page_rcvd(ev[6]),
    .o_irq_n(irq_n));
  link_partner_model lp (
    .i_clk_sys(clk), .o_lcw_ok(lcw_ok), .o_base_sent(base_sent),
    .o_base_toggle(base_tog), .o_np_sent(np_sent));
  // ************************************
  // Checking and bus tasks
  // ************************************
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  // Full APB transfer; waits on pready with a bound, no fixed latency
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Expected page word: only writable bits follow software
  function automatic logic [15:0] np_exp(logic [15:0] d, logic a, logic t);
    return (d & NP_WR_MASK) | {1'b0, a, 2'b00, t, 11'h000};
  endfunction
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic [31:0] q;
    logic        e;
    logic [15:0] d, np, m;
    n_fail = 0; checks_done = 0;
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; ev = 7'h00;
    void'($urandom(63));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Reset values and an unmapped word
    apb(1'b0, ADDR_NP, 32'h0, q, e);
    chk(q, 32'h2001);
    apb(1'b0, ADDR_MASK, 32'h0, q, e);
    chk(q, 32'h4080);
    chk(q, 32'h4080);
    apb(1'b0, 12'hffc, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    // Page writes: all ones, zero, then random
    for (int r = 0; r < 4; r++) begin
      d = (r == 0) ? 16'hffff : (r == 1) ? 16'h0000 : 16'($urandom());
      np = np_exp(d, 1'b0, 1'b0);
      apb(1'b1, ADDR_NP, {16'h0, d}, q, e);
      repeat (2) @(posedge clk);
      #1 chk({16'h0, np_word}, {16'h0, np});
      apb(1'b0, ADDR_NP, 32'h0, q, e);
      chk(q, {16'h0, np});
    end
    // Compatibility mode freezes page and mask
    apb(1'b1, ADDR_CFG, 32'h1, q, e);
    apb(1'b1, ADDR_NP, {16'h0, ~np}, q, e);
    apb(1'b1, ADDR_MASK, 32'h0, q, e);
    apb(1'b0, ADDR_NP, 32'h0, q, e);
    chk(q, {16'h0, np});
    apb(1'b0, ADDR_MASK, 32'h0, q, e);
    chk(q, 32'h4080);
    apb(1'b1, ADDR_CFG, 32'h0, q, e);
    // Every event under all, none and random enables
    for (int r = 0; r < 3; r++) begin
      m = (r == 0) ? EV_IMPL : (r == 1) ? 16'h0 : 16'($urandom()) & EV_IMPL;
      apb(1'b1, ADDR_MASK, {16'h0, m}, q, e);
      apb(1'b0, ADDR_MASK, 32'h0, q, e);
      chk(q, {16'h0, m});
      for (int k = 0; k < 7; k++) begin
        @(posedge clk);
        ev <= 7'h01 << k;
        @(posedge clk);
        ev <= 7'h00;
        repeat (3) @(posedge clk);
        #1 chk({31'h0, irq_n}, {31'h0, ~m[evb[k]]});
        apb(1'b0, ADDR_STAT, 32'h0, q, e);
        chk(q, 32'h1 << evb[k]);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq_n}, 32'h1);
      end
    end
    // Write-one-to-clear: other bits keep the flag, its own bit clears it
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      ev <= 7'h02;
      @(posedge clk);
      ev <= 7'h00;
      apb(1'b1, ADDR_STAT, (r == 0) ? 32'h0000_bfff : 32'h0000_4000, q, e);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq_n}, {31'h0, ~m[EV_LINK] | r[0]});
      apb(1'b0, ADDR_STAT, 32'h0, q, e);
      chk(q, (r == 0) ? 32'h0000_4000 : 32'h0000_0000);
    end
    // Acknowledge and toggle from the far side
    lp.set_ok(1'b1);
    lp.send_base(1'b0);
    repeat (2) @(posedge clk);
    apb(1'b0, ADDR_NP, 32'h0, q, e);
    chk(q, {16'h0, np_exp(np, 1'b1, 1'b1)});
    lp.send_np();
    apb(1'b1, ADDR_NP, 32'h0000ffff, q, e);
    apb(1'b0, ADDR_NP, 32'h0, q, e);
    chk(q, {16'h0, np_exp(16'hffff, 1'b1, 1'b0)});
    #1 chk({16'h0, np_word}, {16'h0, np_exp(16'hffff, 1'b1, 1'b0)});
    print_verdict();
  end
endmodule // next_page_tx_and_irq_mask_tb_top
`default_nettype wire

/* np_sync_ctl.sv */
// Acknowledge and toggle state for the next-page exchange.
// Assumes the negotiation engine gives sent pulses and a level for ack.
`timescale 1ns/1ps
`default_nettype none
module np_sync_ctl (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  // Negotiation engine
  input  wire logic i_lcw_ok,       // Consistent word received
  input  wire logic i_base_sent,    // Base page sent pulse
  input  wire logic i_base_toggle,  // Toggle of that base page
  input  wire logic i_np_sent,      // Next page sent pulse
  // State
  output var  logic o_ack,          // Acknowledge flag
  output var  logic o_toggle        // Toggle flag
);
  // ******************************
  // Acknowledge tracks the receiver
  // ******************************
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
    end else begin
      o_ack <= i_lcw_ok;
    end
  end
  // ******************************
  // Toggle flips on every next page not sent with a base page
  // ******************************
  // Base page seeds it so the first next page is inverted from it
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_toggle <= 1'b0;
    end else if (i_base_sent) begin
      o_toggle <= ~i_base_toggle;
    end else if (i_np_sent) begin
      o_toggle <= ~o_toggle;
    end
  end
endmodule // np_sync_ctl
`default_nettype wire

/* phy_mgmt_pkg.sv */
// Constants shared by the next-page and interrupt-mask register logic.
// Assumes one 100 MHz clock and an APB register bus of 32-bit data.
`default_nettype none
package phy_mgmt_pkg;
  // ******************************
  // Register indices and addresses
  // ******************************
  localparam logic [9:0]  IDX_NP   = 10'h007;   // Next-page transmit
  localparam logic [9:0]  IDX_MASK = 10'h010;   // Interrupt enable mask
  localparam logic [9:0]  IDX_STAT = 10'h011;   // Interrupt status
  localparam logic [9:0]  IDX_CFG  = 10'h01c;   // Configuration
  localparam logic [11:0] ADDR_NP   = {IDX_NP, 2'b00};
  localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [11:0] ADDR_CFG  = {IDX_CFG, 2'b00};
  // ******************************
  // Field positions
  // ******************************
  localparam int NP_MORE   = 15;  // More pages follow
  localparam int NP_ACK    = 14;  // Link code word acknowledge
  localparam int NP_MSG    = 13;  // Message page selector
  localparam int NP_COMPLY = 12;  // Comply acknowledge
  localparam int NP_TOGGLE = 11;  // Toggle
  localparam int CFG_COMPAT = 0;  // Legacy compatibility mode
  localparam int EV_UNSTABLE = 15;
  localparam int EV_LINK     = 14;
  localparam int EV_DESCR    = 13;
  localparam int EV_PREMEND  = 12;
  localparam int EV_RSTDONE  = 7;
  localparam int EV_ANDONE   = 5;
  localparam int EV_PAGE     = 1;
  // ******************************
  // Masks and reset values
  // ******************************
  localparam logic [15:0] NP_WR_MASK  = 16'hb7ff;  // Writable page bits
  localparam logic [15:0] NP_RST      = 16'h2001;  // Message, null code
  localparam logic [15:0] EV_IMPL     = 16'hf0a2;  // Implemented events
  localparam logic [15:0] MASK_RST    = 16'h4080;  // Link and reset done
endpackage
`default_nettype wire
